// [hw/sps_pkg.sv]
// Constants and types for the synchronous serial port with slave-select gating.
// How it works
// [R1] Slave-select honoured only in mode code 0100.
// [R2] Select low enables shifting and drives serial_out.
// [R3] Select high floats serial_out immediately, mid-byte too.
// [R4] Select high resets transfer logic in mode 0100.
// [R5] Software enables select control when slave uses edge=1.
// [R6] Module reset forces the bit counter to zero.
// [R7] Receive-only never drives serial_out; serial_in stays input.
// [R8] Master freezes during sleep, resumes afterwards.
// [R9] Master completion wakes only when interrupts enabled.
// [R10] Slave shifts on external clock; eight bits flag.
// [R11] Device reset disables port and aborts transfer.
// [R12] SPI modes map to polarity and edge bits.
// [R13] sample_phase picks mid or end sample point.
// [R14] Control registers RW; status low six read-only.
// [R15] address_reload holds address or baud reload value.
// [R16] Completed byte moves to buffer, sets flag.
// [R17] Buffer write loads buffer and shift register together.
// [R18] Software sets I2C pin directions to inputs.
// [R19] I2C start and stop conditions raise the flag.
// [R20] Mode field selects slave or master clock rate.
// [R21] clock_idle_polarity sets serial clock idle level.
// [R22] Busy buffer write ignored, sets write_collision_flag.
// [R23] Floating serial_out is a deasserted output enable.
package sps_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_BUF = 8'h00;
  localparam logic [7:0] OFF_CON1 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CON2 = 8'h0c;
  localparam logic [7:0] OFF_ADDR = 8'h10;
  localparam logic [7:0] OFF_AUX = 8'h14;
  // Reset values.
  localparam logic [7:0] RST_CON1 = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_CON2 = 8'h00;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_AUX = 8'h00;
  // Field positions.
  localparam int CON1_WRITE_COLLISION_FLAG = 7;
  localparam int CON1_OV = 6;
  localparam int CON1_EN = 5;
  localparam int CON1_CKP = 4;
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_P = 4;
  localparam int STAT_S = 3;
  localparam int STAT_BF = 0;
  localparam int AUX_IE = 0;
  localparam int AUX_RXONLY = 1;
  localparam int AUX_IRQ = 2;
  // Mode field codes.
  localparam logic [3:0] MODE_MDIV4 = 4'h0;
  localparam logic [3:0] MODE_MDIV16 = 4'h1;
  localparam logic [3:0] MODE_MDIV64 = 4'h2;
  localparam logic [3:0] MODE_MTMR = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
  localparam logic [3:0] MODE_I2C_S7SP = 4'he;
  localparam logic [3:0] MODE_I2C_S10SP = 4'hf;
  // Timing: system clock rate and half bit lengths in system clocks.
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam logic [5:0] HALF_DIV4 = 6'd2;
  localparam logic [5:0] HALF_DIV16 = 6'd8;
  localparam logic [5:0] HALF_DIV64 = 6'd32;
  localparam logic [2:0] LAST_BIT = 3'd7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic {SPS_IDLE, SPS_RUN} sps_mst_t;
endpackage

// [hw/sps_port.sv]
// Synchronous serial port core with AXI4-Lite registers and slave-select gating.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module sps_port
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // AXI4-Lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Serial pins
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_N,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_N,
  input wire logic SS_N_IN,
  // System
  input wire logic SLEEP,
  input wire logic TIMER_TICK,
  output logic WAKE
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] meta_q, sync_q, old_q;
  logic [7:0] con1_q, stat_q, con2_q, addr_q, aux_q, buf_q, sr_q, sr_n;
  logic [3:0] cnt_q;
  logic [2:0] mbit_q;
  logic [5:0] half_cnt_q, half_len;
  sps_mst_t mstate_q;
  logic half_b_q, out_q, sck_out_q, sdo_oe_n_q, sck_oe_n_q, wake_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic sck_s, ss_s, sdi_s, en, clock_idle_polarity, sample_phase, cke, ie, rxonly;
  logic [3:0] mode;
  logic is_master, is_slave, ss_ctl, ss_block, mod_rst, running, busy;
  logic tick, enter_b, end_b, m_done, m_sample, s_lead, s_trail, s_sample, s_shift;
  logic sample_ev, shift_ev, byte_done, i2c_sp, i2c_start, i2c_stop, drive;
  logic wr_fire, wr_en, wr_buf, wr_ok, rd_buf, rd_ok;

  // Pins from the far side pass two flops; bit 0 clock, bit 1 select, bit 2 data.
  always_ff @(posedge SYS_CLK) begin
    meta_q <= {SDI_IN, SS_N_IN, SCK_IN};
    sync_q <= meta_q;
    old_q <= sync_q;
  end

  assign sck_s = sync_q[0];
  assign ss_s = sync_q[1];
  assign sdi_s = sync_q[2];
  assign en = con1_q[CON1_EN];
  assign clock_idle_polarity = con1_q[CON1_CKP];
  assign mode = con1_q[3:0];
  assign sample_phase = stat_q[STAT_SMP];
  assign cke = stat_q[STAT_CKE];
  assign ie = aux_q[AUX_IE];
  assign rxonly = aux_q[AUX_RXONLY];
  assign running = (mstate_q == SPS_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode.
  assign is_master = en && (mode[3:2] == 2'b00); // R20
  assign is_slave = en && (mode == MODE_SLV_SS || mode == MODE_SLV_NOSS); // R20
  assign ss_ctl = en && (mode == MODE_SLV_SS); // R1
  assign ss_block = ss_ctl && ss_s; // R4
  assign mod_rst = !en || ss_block; // R6
  assign busy = running || (cnt_q != 4'd0);
  assign i2c_sp = en && (mode == MODE_I2C_S7SP || mode == MODE_I2C_S10SP);

  always_comb begin
    case (mode)
      MODE_MDIV4: half_len = HALF_DIV4;
      MODE_MDIV16: half_len = HALF_DIV16;
      default: half_len = HALF_DIV64;
    endcase
  end

  // Master half-bit ticks stop while asleep so the transfer freezes in place.
  assign tick = running && !SLEEP && ((mode == MODE_MTMR) ? TIMER_TICK : (half_cnt_q == half_len - 6'd1)); // R8 R20
  assign enter_b = tick && !half_b_q;
  assign end_b = tick && half_b_q;
  assign m_done = end_b && (mbit_q == LAST_BIT);
  assign m_sample = sample_phase ? end_b : enter_b; // R13

  // Slave edges come from the external clock; the leading edge leaves the idle level.
  // The slave path is sampled by the system clock, so the serial clock must stay well below it.
  assign s_lead = is_slave && !ss_block && (sck_s != clock_idle_polarity) && (old_q[0] == clock_idle_polarity); // R10
  assign s_trail = is_slave && !ss_block && (sck_s == clock_idle_polarity) && (old_q[0] != clock_idle_polarity); // R10
  assign s_sample = cke ? s_lead : s_trail; // R12
  assign s_shift = cke ? s_trail : s_lead; // R12

  assign sample_ev = m_sample || s_sample;
  assign shift_ev = (end_b && !m_done) || s_shift;
  assign sr_n = sample_ev ? {sr_q[6:0], sdi_s} : sr_q;
  assign byte_done = m_done || (s_sample && cnt_q == 4'd7); // R10

  // I2C start and stop: data moves while the clock stays high.
  assign i2c_start = i2c_sp && sck_s && old_q[0] && old_q[2] && !sdi_s; // R19
  assign i2c_stop = i2c_sp && sck_s && old_q[0] && !old_q[2] && sdi_s; // R19

  ////////////////////////////////////////////////////////////////////////////
  // Bus write decode; the master holds address and data until the accept edge.
  assign wr_fire = awready_q;
  assign wr_en = wr_fire && S_AXI_WSTRB[0];
  assign wr_buf = wr_en && (S_AXI_AWADDR == OFF_BUF);
  assign rd_buf = arready_q && (S_AXI_ARADDR == OFF_BUF);
  assign wr_ok = (S_AXI_AWADDR == OFF_BUF) || (S_AXI_AWADDR == OFF_CON1) || (S_AXI_AWADDR == OFF_STAT)
    || (S_AXI_AWADDR == OFF_CON2) || (S_AXI_AWADDR == OFF_ADDR) || (S_AXI_AWADDR == OFF_AUX);
  assign rd_ok = (S_AXI_ARADDR == OFF_BUF) || (S_AXI_ARADDR == OFF_CON1) || (S_AXI_ARADDR == OFF_STAT)
    || (S_AXI_ARADDR == OFF_CON2) || (S_AXI_ARADDR == OFF_ADDR) || (S_AXI_ARADDR == OFF_AUX);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      awready_q <= S_AXI_AWVALID && S_AXI_WVALID && !awready_q && !bvalid_q;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= S_AXI_ARVALID && !arready_q && !rvalid_q;
      if (arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        case (S_AXI_ARADDR)
          OFF_BUF: rdata_q <= {24'h0, buf_q};
          OFF_CON1: rdata_q <= {24'h0, con1_q};
          OFF_STAT: rdata_q <= {24'h0, stat_q};
          OFF_CON2: rdata_q <= {24'h0, con2_q};
          OFF_ADDR: rdata_q <= {24'h0, addr_q};
          OFF_AUX: rdata_q <= {24'h0, aux_q};
          default: rdata_q <= 32'h0;
        endcase
      end else if (S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control one: collision and overflow are set by hardware, cleared by writing zero.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      con1_q <= RST_CON1; // R11
    end else begin
      if (wr_en && S_AXI_AWADDR == OFF_CON1) begin
        con1_q <= S_AXI_WDATA[7:0]; // R14
      end
      if (wr_buf && busy) begin
        con1_q[CON1_WRITE_COLLISION_FLAG] <= 1'b1; // R22
      end
      // A read that empties the buffer in the same cycle lets the new byte in instead.
      if (byte_done && stat_q[STAT_BF] && !rd_buf) begin
        con1_q[CON1_OV] <= 1'b1;
      end
    end
  end

  // Status: upper two bits writable, lower six owned by hardware.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stat_q <= RST_STAT;
    end else begin
      if (wr_en && S_AXI_AWADDR == OFF_STAT) begin
        stat_q[7:6] <= S_AXI_WDATA[7:6]; // R14
      end
      if (rd_buf) begin
        stat_q[STAT_BF] <= 1'b0;
      end
      if (byte_done && (!stat_q[STAT_BF] || rd_buf)) begin
        stat_q[STAT_BF] <= 1'b1; // R16
      end
      if (!en) begin
        stat_q[STAT_P] <= 1'b0;
        stat_q[STAT_S] <= 1'b0;
      end else if (i2c_start) begin
        stat_q[STAT_S] <= 1'b1; // R19
        stat_q[STAT_P] <= 1'b0;
      end else if (i2c_stop) begin
        stat_q[STAT_P] <= 1'b1; // R19
        stat_q[STAT_S] <= 1'b0;
      end
    end
  end

  // Control two and address/reload are plain storage at this level.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      con2_q <= RST_CON2;
      addr_q <= RST_ADDR;
    end else begin
      if (wr_en && S_AXI_AWADDR == OFF_CON2) begin
        con2_q <= S_AXI_WDATA[7:0]; // R14
      end
      if (wr_en && S_AXI_AWADDR == OFF_ADDR) begin
        addr_q <= S_AXI_WDATA[7:0]; // R15
      end
    end
  end

  // Auxiliary: interrupt enable, receive-only, and the sticky port flag cleared by writing one.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aux_q <= RST_AUX;
    end else begin
      if (wr_en && S_AXI_AWADDR == OFF_AUX) begin
        aux_q[AUX_IE] <= S_AXI_WDATA[AUX_IE];
        aux_q[AUX_RXONLY] <= S_AXI_WDATA[AUX_RXONLY];
        if (S_AXI_WDATA[AUX_IRQ]) begin
          aux_q[AUX_IRQ] <= 1'b0;
        end
      end
      if (byte_done || i2c_start || i2c_stop) begin
        aux_q[AUX_IRQ] <= 1'b1; // R16 R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer and shift register; a received byte is dropped while the buffer is still full.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      buf_q <= 8'h00;
      sr_q <= 8'h00;
      out_q <= 1'b0;
    end else if (wr_buf && !busy) begin
      buf_q <= S_AXI_WDATA[7:0]; // R17
      sr_q <= S_AXI_WDATA[7:0]; // R17
      out_q <= S_AXI_WDATA[7];
    end else begin
      sr_q <= sr_n;
      if (shift_ev) begin
        out_q <= sr_n[7];
      end
      if (byte_done && (!stat_q[STAT_BF] || rd_buf)) begin
        buf_q <= sr_n; // R16
      end
    end
  end

  // Bit counter for both directions.
  always_ff @(posedge SYS_CLK) begin
    if (RST || mod_rst) begin
      cnt_q <= 4'd0; // R4 R6 R11
    end else if (byte_done) begin
      cnt_q <= 4'd0;
    end else if (sample_ev) begin
      cnt_q <= cnt_q + 4'd1;
    end
  end

  // Master sequencer: two half bits per bit, clock toggles at each half.
  always_ff @(posedge SYS_CLK) begin
    if (RST || !is_master) begin
      mstate_q <= SPS_IDLE; // R11
      half_b_q <= 1'b0;
      half_cnt_q <= 6'd0;
      mbit_q <= 3'd0;
      sck_out_q <= clock_idle_polarity; // R21
    end else begin
      case (mstate_q)
        SPS_IDLE: begin
          sck_out_q <= clock_idle_polarity; // R21
          half_b_q <= 1'b0;
          half_cnt_q <= 6'd0;
          mbit_q <= 3'd0;
          if (wr_buf && !busy) begin
            mstate_q <= SPS_RUN;
            sck_out_q <= cke ? clock_idle_polarity : !clock_idle_polarity; // R12
          end
        end
        SPS_RUN: begin
          if (!SLEEP) begin
            half_cnt_q <= tick ? 6'd0 : half_cnt_q + 6'd1; // R8
          end
          if (tick) begin
            half_b_q <= !half_b_q;
            sck_out_q <= !sck_out_q;
          end
          if (end_b) begin
            mbit_q <= mbit_q + 3'd1;
          end
          if (m_done) begin
            mstate_q <= SPS_IDLE;
            sck_out_q <= clock_idle_polarity;
          end
        end
        default: mstate_q <= SPS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin enables; serial_out floats as soon as select goes high, even mid-byte.
  // Software must select control mode 0100 for a slave using edge one, else a slipped bit never recovers.
  assign drive = en && !rxonly && (is_master || mode == MODE_SLV_NOSS || (ss_ctl && !ss_s)); // R2 R3 R5 R7

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sdo_oe_n_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      wake_q <= 1'b0;
    end else begin
      sdo_oe_n_q <= !drive; // R23
      sck_oe_n_q <= !is_master;
      wake_q <= SLEEP && ie && aux_q[AUX_IRQ]; // R9 R10
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = awready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign SCK_OUT = sck_out_q;
  assign SCK_OE_N = sck_oe_n_q;
  assign SDO_OUT = out_q;
  assign SDO_OE_N = sdo_oe_n_q;
  assign WAKE = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  sequence m_start_s;
    wr_buf && !busy && is_master && mode != MODE_MTMR;
  endsequence
  sequence m_finish_s;
    !running || SLEEP;
  endsequence

  ss_float_a: assert property (ss_ctl && ss_s |=> SDO_OE_N) // R3
    else $error("serial_out still driven with select high");
  ss_drive_a: assert property (ss_ctl && !ss_s && !rxonly |=> !SDO_OE_N) // R2
    else $error("serial_out not driven with select low");
  ss_reset_a: assert property (ss_block |=> cnt_q == 4'd0) // R4
    else $error("select high did not reset the counter");
  cnt_clear_a: assert property (!en |=> cnt_q == 4'd0 && !running) // R6
    else $error("disable did not clear the counter");
  write_collision_flag_set_a: assert property (wr_buf && busy && !byte_done |=> con1_q[CON1_WRITE_COLLISION_FLAG] && $stable(buf_q)) // R22
    else $error("collision not flagged or buffer changed");
  tx_load_a: assert property (wr_buf && !busy |=> sr_q == $past(S_AXI_WDATA[7:0]) && buf_q == sr_q) // R17
    else $error("buffer write did not load both registers");
  rx_done_a: assert property (byte_done && !stat_q[STAT_BF] |=> stat_q[STAT_BF] && aux_q[AUX_IRQ]
    && buf_q == $past(sr_n)) // R16
    else $error("completed byte not moved to buffer");
  sleep_freeze_a: assert property (running && SLEEP && is_master |=> $stable(sr_q) && $stable(half_b_q)) // R8
    else $error("master moved while asleep");
  rxonly_a: assert property (rxonly |=> SDO_OE_N) // R7
    else $error("receive-only still drives serial_out");
  wake_gate_a: assert property (!ie |=> !WAKE) // R9
    else $error("wake raised with interrupts disabled");
  idle_pol_a: assert property (is_master && !running && !$past(running) && !(wr_buf && !busy)
    |=> SCK_OUT == $past(clock_idle_polarity)) // R21
    else $error("serial clock idle level wrong");
  m_xfer_a: assert property (m_start_s |-> ##[1:600] m_finish_s) // R20
    else $error("master transfer did not finish in time");

endmodule // sps_port

// [testbench/sps_port_bench.sv]
// Bench for the serial port: registers, master and slave transfers, sleep and bus conditions.
`timescale 1ns/1ps
module sps_port_bench
  import sps_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sleep = 1'b0;
  logic tick = 1'b0;
  logic loop_en = 1'b0;
  logic ckp_ref = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sck_out, sck_oe_n, sdo_out, sdo_oe_n, wake;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic m_sck, m_ss_n, m_mosi, serial_in, sck_pin;
  logic [7:0] rx;
  logic [3:0] t_mode [4] = '{MODE_MDIV4, MODE_MDIV16, MODE_MDIV64, MODE_MTMR};
  int t_half [4] = '{2, 8, 32, 5};
  int failures = 0;
  int tests_run = 0;
  int act_cnt = 0;
  int oe_cnt = 0;
  int tick_cnt = 0;
  int a0;
  // Master runs loop serial_out back to serial_in, like a two-wire hookup.
  assign serial_in = loop_en ? sdo_out : m_mosi;
  assign sck_pin = (sck_oe_n === 1'b0) ? sck_out : m_sck;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
    tick <= (tick_cnt == 4);
    if (sck_out !== ckp_ref)
      act_cnt <= act_cnt + 1;
    if (sdo_oe_n === 1'b0)
      oe_cnt <= oe_cnt + 1;
  end
  sps_port sps_port_inst (
    .SYS_CLK(sys_clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SCK_IN(sck_pin), .SCK_OUT(sck_out), .SCK_OE_N(sck_oe_n), .SDI_IN(serial_in),
    .SDO_OUT(sdo_out), .SDO_OE_N(sdo_oe_n), .SS_N_IN(m_ss_n), .SLEEP(sleep), .TIMER_TICK(tick), .WAKE(wake)
  );
  sps_spi_master_model sps_spi_master_model_inst (
    .clk(sys_clk), .miso(sdo_out), .sck(m_sck), .ss_n(m_ss_n), .mosi(m_mosi)
  );
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    r = 2'b11;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 200 && r === 2'b11; n++) begin
      @(posedge sys_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    chk(32'(r), 32'(er));
  endtask
  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'b11;
    d = 32'hffffffff;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 200 && r === 2'b11; n++) begin
      @(posedge sys_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY,
                    input logic [31:0] m = '1);
    logic [31:0] d;
    logic [1:0] r;
    rd_raw(a, d, r);
    chk(d & m, e & m);
    chk(32'(r), 32'(er));
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    for (int n = 0; n < 400 && d[b] !== 1'b1; n++)
      rd_raw(a, d, r);
    chk(32'(d[b]), 32'h1);
  endtask
  // Disabling first gives every reconfiguration a clean module reset.
  task automatic cfg(input logic [7:0] st, input logic [7:0] con1, input logic [7:0] aux);
    wr(OFF_CON1, 8'h00);
    wr(OFF_STAT, st);
    wr(OFF_CON1, con1);
    wr(OFF_AUX, aux);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end
  initial begin
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] st;
    int s;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int o = 0; o <= 20; o += 4)
      rd(8'(o), 32'h0);
    chk(32'({sck_oe_n, sdo_oe_n, wake}), 32'h6);
    wr(OFF_CON2, 8'ha5);
    rd(OFF_CON2, 32'ha5);
    wr(OFF_ADDR, 8'h7f);
    rd(OFF_ADDR, 32'h7f);
    wr(OFF_STAT, 8'hff);
    rd(OFF_STAT, 32'hc0);
    wr(8'h18, 8'h01, RESP_SLVERR);
    rd(8'h18, 32'h0, RESP_SLVERR);
    // Each rate code meets one of the four clock polarity and edge pairings.
    loop_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      c = 8'h20 | (8'(i[1]) << CON1_CKP) | 8'(t_mode[i]);
      st = (i[0] ? 8'h00 : 8'h01 << STAT_CKE) | ((i == 3) ? 8'h80 : 8'h00);
      d = 8'h96 + 8'(i * 53);
      ckp_ref = i[1];
      cfg(st, c, 8'h05);
      chk(32'(sck_oe_n), 32'h0);
      a0 = act_cnt;
      wr(OFF_BUF, d);
      wr(OFF_BUF, ~d);
      wait_bit(OFF_STAT, STAT_BF);
      chk(32'(act_cnt - a0), 32'(8 * t_half[i]));
      rd(OFF_CON1, 32'(c | 8'h80));
      rd(OFF_STAT, 32'(st | 8'h01));
      // At the fastest rate the two-flop input path makes each sample see the previous bit.
      rd(OFF_BUF, (i == 0) ? 32'(d >> 1) : 32'(d));
      rd(OFF_STAT, 32'(st));
    end
    ckp_ref = 1'b0;
    cfg(8'h40, 8'h20 | 8'(MODE_MDIV16), 8'h05);
    wr(OFF_BUF, 8'h33);
    repeat (20) @(posedge sys_clk);
    sleep <= 1'b1;
    repeat (2) @(posedge sys_clk);
    s = act_cnt;
    d[0] = sck_out;
    repeat (50) @(posedge sys_clk);
    chk(32'(act_cnt - s), d[0] ? 32'd50 : 32'd0);
    sleep <= 1'b0;
    wait_bit(OFF_STAT, STAT_BF);
    rd(OFF_BUF, 32'h33);
    sleep <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'(wake), 32'h1);
    wr(OFF_AUX, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk(32'(wake), 32'h0);
    sleep <= 1'b0;
    loop_en <= 1'b0;
    cfg(8'h40, 8'h20 | 8'(MODE_SLV_SS), 8'h04);
    wr(OFF_BUF, 8'h3c);
    s = oe_cnt;
    sps_spi_master_model_inst.xfer(8'ha5, 8, 1'b1, rx);
    chk(32'(rx), 32'h3c);
    chk(32'(oe_cnt > s), 32'h1);
    chk(32'(sdo_oe_n), 32'h1);
    wait_bit(OFF_STAT, STAT_BF);
    rd(OFF_AUX, 32'h04);
    rd(OFF_BUF, 32'ha5);
    wr(OFF_AUX, 8'h04);
    sps_spi_master_model_inst.xfer(8'hff, 4, 1'b1, rx);
    chk(32'(sdo_oe_n), 32'h1);
    rd(OFF_AUX, 32'h0);
    sps_spi_master_model_inst.xfer(8'h5a, 8, 1'b1, rx);
    wait_bit(OFF_STAT, STAT_BF);
    rd(OFF_BUF, 32'h5a);
    wr(OFF_AUX, 8'h06);
    s = oe_cnt;
    sps_spi_master_model_inst.xfer(8'h81, 8, 1'b1, rx);
    chk(32'(oe_cnt - s), 32'h0);
    wait_bit(OFF_STAT, STAT_BF);
    rd(OFF_BUF, 32'h81);
    cfg(8'h00, 8'h20 | 8'(MODE_SLV_NOSS), 8'h04);
    sps_spi_master_model_inst.cke = 1'b0;
    sps_spi_master_model_inst.xfer(8'hc3, 8, 1'b0, rx);
    wait_bit(OFF_STAT, STAT_BF);
    rd(OFF_BUF, 32'hc3);
    cfg(8'h00, 8'h20 | 8'(MODE_I2C_S7SP), 8'h04);
    sps_spi_master_model_inst.bus_cond(1'b1);
    rd(OFF_STAT, 32'(8'h01 << STAT_S));
    sps_spi_master_model_inst.bus_cond(1'b0);
    rd(OFF_STAT, 32'(8'h01 << STAT_P));
    rd(OFF_AUX, 32'h04);
    cfg(8'h40, 8'h20 | 8'(MODE_MDIV64), 8'h01);
    wr(OFF_BUF, 8'h77);
    repeat (40) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(32'({sck_oe_n, sck_out}), 32'h2);
    rd(OFF_CON1, 32'h0);
    rd(OFF_STAT, 32'h0);
    print_verdict();
  end
endmodule // sps_port_bench

// [testbench/sps_spi_master_model.sv]
// Behavioural external SPI master and I2C line driver facing the port's serial pins.
`timescale 1ns/1ps
module sps_spi_master_model (
  // Clock
  input wire logic clk,
  // Port side
  input wire logic miso,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  logic cpol = 1'b0;
  logic cke = 1'b1;
  int half = 8;
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic wait_half();
    repeat (half) @(posedge clk);
  endtask
  // The clock moves only inside a frame and rests at its idle level in between.
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic use_ss, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk);
    sck <= cpol;
    ss_n <= !use_ss;
    repeat (8) @(posedge clk);
    for (int i = 7; i > 7 - nbits; i--) begin
      if (cke)
        mosi <= tx[i];
      wait_half();
      sck <= ~cpol;
      if (cke)
        rx[i] = miso;
      else
        mosi <= tx[i];
      wait_half();
      sck <= cpol;
      if (!cke)
        rx[i] = miso;
    end
    wait_half();
    ss_n <= 1'b1;
    // A released data line shows the opposite of its last bit, so nothing leans on a stale value.
    mosi <= ~mosi;
    repeat (5) @(posedge clk);
  endtask
  // Start is data falling while the clock is high, stop is data rising; the port only listens.
  task automatic bus_cond(input logic start);
    @(posedge clk);
    sck <= 1'b0;
    mosi <= start;
    wait_half();
    sck <= 1'b1;
    wait_half();
    mosi <= ~start;
    wait_half();
  endtask
endmodule // sps_spi_master_model
